// ==== sim/pmc_osc_model.sv ====
// oscillator sources seen by the clock mode controller
// assumes enables are registered on i_clk; ready levels are handed on raw
`timescale 1ns/1ps
`default_nettype none

module pmc_osc_model
#(
    parameter int PRI_START = 8,
    parameter int SEC_START = 5,
    parameter int FAST_START = 2
)
(
    // clock
    input wire logic i_clk,
    // oscillator enables
    input wire logic i_pri_en,
    input wire logic i_sec_en,
    input wire logic i_fast_en,
    // ready levels
    output logic o_pri_ready,
    output logic o_sec_ready,
    output logic o_fast_ready
);
    // =========================================================
    // start-up counters
    // a stopped source drops ready on the next i_clk edge, so no stale level survives
    int pri_n = 0;
    int sec_n = 0;
    int fast_n = 0;
    always @(posedge i_clk)
    begin
        pri_n <= i_pri_en ? pri_n + 1 : 0;
        sec_n <= i_sec_en ? sec_n + 1 : 0;
        fast_n <= i_fast_en ? fast_n + 1 : 0;
    end
    assign o_pri_ready = pri_n >= PRI_START;
    assign o_sec_ready = sec_n >= SEC_START;
    assign o_fast_ready = fast_n >= FAST_START;
endmodule
`default_nettype wire

// ==== sim/pmc_tb.sv ====
// self-checking bench of the clock mode controller
// assumes oscillator model feeds ready levels; straps held as set here
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk, rst, wr, rd, slp, irq, wdt, wdt_sel, zero, two_spd, pri_int;
    logic [1:0] addr;
    logic [7:0] wdata;
    wire logic [7:0] rdata;
    wire logic [1:0] sys_sel;
    wire logic [2:0] freq;
    wire logic cpu_en, per_en, pri_en, sec_en, fast_en, slow_en;
    wire logic f_pri, f_int, f_sec, p_rdy, s_rdy, q_rdy;
    wire logic [7:0] flags;
    int mismatches = 0;
    int cmp_count = 0;
    assign flags = {5'h00, f_pri, f_int, f_sec};

    // =========================================================
    // design and oscillators
    pmc_clock_modes uut (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
        .I_WR_DATA(wdata), .I_WR_STB(wr), .I_RD_STB(rd), .O_RD_DATA(rdata),
        .I_SLEEP_EXEC(slp), .I_WAKE_IRQ(irq), .I_WDT_TIMEOUT(wdt),
        .I_TWO_SPEED_EN(two_spd), .I_FAILSAFE_EN(zero),
        .I_WDT_SELECTED(wdt_sel), .I_PRI_IS_INTERNAL(pri_int),
        .I_PRI_READY(p_rdy), .I_SEC_READY(s_rdy), .I_FAST_INT_READY(q_rdy),
        .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en),
        .O_SYS_CLK_SEL(sys_sel), .O_INT_FREQ_SEL(freq),
        .O_PRI_OSC_EN(pri_en), .O_SEC_OSC_EN(sec_en),
        .O_FAST_INT_OSC_EN(fast_en), .O_SLOW_INT_OSC_EN(slow_en),
        .O_PRIMARY_RUNNING_FLAG(f_pri), .O_INTERNAL_STABLE_FLAG(f_int),
        .O_SECONDARY_RUNNING_FLAG(f_sec));
    pmc_osc_model osc (.i_clk(clk), .i_pri_en(pri_en), .i_sec_en(sec_en),
        .i_fast_en(fast_en), .o_pri_ready(p_rdy), .o_sec_ready(s_rdy),
        .o_fast_ready(q_rdy));

    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // =========================================================
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask

    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1;
        chk(rdata, exp);
    endtask

    // waits for the gate gap of a switch and measures it
    task automatic sw(input logic [1:0] a, input logic [7:0] d,
        input logic [1:0] esel);
        int n;
        int k;
        n = 0;
        k = 0;
        wr_reg(a, d);
        while (per_en !== 0 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (per_en === 0 && k < 50)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(8'(k), 8'(2 * pmc_pkg::SWITCH_CYC));
        chk(8'(sys_sel), 8'(esel));
    endtask

    // counts edges from a wake until the cpu gate opens
    task automatic wake_wait(output int n);
        n = 0;
        #1;
        while (cpu_en !== 1 && n < 300)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic sleep_cmd;
        @(posedge clk);
        slp <= 1;
        @(posedge clk);
        slp <= 0;
        #1;
    endtask

    task tally_and_finish;
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic idle_t;
        int n;
        wr_reg(2'h0, 8'hB0);
        sleep_cmd();
        chk(8'(cpu_en), 8'h00);
        chk(8'(per_en), 8'h01);
        chk(flags, 8'h04);
        chk(8'(pri_en), 8'h01);
        @(posedge clk);
        irq <= 1;
        @(posedge clk);
        irq <= 0;
        wake_wait(n);
        chk(8'(n), 8'(pmc_pkg::CPU_READY_CYC));
        rd_reg(2'h0, 8'hB8);
        wr_reg(2'h0, 8'h30);
    endtask

    task automatic sec_t;
        wr_reg(2'h0, 8'h31);
        repeat (20) @(posedge clk);
        #1;
        chk(8'(sys_sel), 8'h00);
        sw(2'h1, 8'h01, 2'h1);
        chk(flags, 8'h01);
        chk(8'(pri_en), 8'h00);
        rd_reg(2'h1, 8'h03);
        sw(2'h0, 8'h30, 2'h0);
        chk(flags, 8'h04);
        chk(8'(sec_en), 8'h01);
    endtask

    task automatic int_t;
        sw(2'h0, 8'h52, 2'h2);
        chk(8'(freq), 8'h05);
        chk(flags, 8'h02);
        chk(8'(pri_en), 8'h00);
        wr_reg(2'h0, 8'h23);
        #1;
        chk(8'(freq), 8'h02);
        chk(8'(sys_sel), 8'h02);
        sw(2'h0, 8'h30, 2'h0);
        chk(flags, 8'h04);
    endtask

    task automatic sleep_t;
        int n;
        sleep_cmd();
        chk(8'({per_en, cpu_en}), 8'h00);
        chk(flags, 8'h00);
        chk(8'(pri_en), 8'h00);
        chk(8'({slow_en, sec_en}), 8'h03);
        @(posedge clk);
        wdt <= 1;
        @(posedge clk);
        wdt <= 0;
        wake_wait(n);
        chk(8'(cpu_en), 8'h01);
        @(posedge clk);
        #1;
        chk(flags, 8'h04);
        rd_reg(2'h0, 8'h38);
        rd_reg(2'h1, 8'h01);
    endtask

    task automatic pri_int_t;
        @(posedge clk);
        pri_int <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(flags, 8'h06);
        chk(8'(fast_en), 8'h01);
        @(posedge clk);
        pri_int <= 1'b0;
    endtask

    // sleep long enough for the synced ready of the primary to drop
    task automatic fast_wake_t;
        int n;
        @(posedge clk);
        two_spd <= 1'b1;
        sleep_cmd();
        repeat (4) @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        wake_wait(n);
        chk(8'(sys_sel), 8'h02);
        repeat (40) @(posedge clk);
        two_spd <= 1'b0;
        #1;
        chk(8'(sys_sel), 8'h00);
        chk(flags, 8'h04);
    endtask

    initial
    begin
        {rst, wr, rd, slp, irq, wdt, wdt_sel, zero} = 8'h80;
        wdt_sel = 1;
        {two_spd, pri_int} = 2'h0;
        addr = 2'h0;
        wdata = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 0;
        repeat (30) @(posedge clk);
        #1;
        chk(8'(cpu_en), 8'h01);
        chk(flags, 8'h04);
        rd_reg(2'h0, 8'h38);
        rd_reg(2'h1, 8'h00);
        rd_reg(2'h2, 8'h01);
        wr_reg(2'h3, 8'hFF);
        rd_reg(2'h3, 8'h00);
        idle_t();
        sec_t();
        int_t();
        pri_int_t();
        sleep_t();
        fast_wake_t();
        tally_and_finish();
    end

    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== verilog/pmc_clock_modes.sv ====
// power-managed clock mode controller: run, idle and sleep sequencing
// assumes cpu strobes, wake events and straps come from I_CLK logic;
// oscillator ready levels arrive asynchronously and are synchronised
//
// Operation
// - switch waits new start-up plus 2.5+2.5 cycles
// - status flags encode the active main clock
// - idle-enable sampled when sleep instruction executes
// - sleep with idle clear stops every clock
// - sleep with idle set stops only cpu
// - reset enters primary run, primary flag set
// - primary run sets internal flag if internal primary
// - select 01 moves to secondary, primary off
// - secondary entry postponed until enabled and ready
// - secondary to primary waits primary ready, flags
// - secondary oscillator runs while its enable set
// - upper select bit picks internal run mode
// - frequency select write changes speed immediately
// - internal run entry and exit use switch delay
// - internal to primary waits primary ready, flags
// - sleep shuts oscillator, clears flags, no switch
// - watchdog and secondary oscillators survive sleep/idle
// - sleep wake waits ready or uses internal
// - idle clocks peripherals only, flags unchanged
// - idle exits on wake after cpu-ready delay
// - watchdog time-out wakes to selected run mode
// - primary idle keeps primary running, flag set
// - cpu starts on first cycle after delay
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pmc_clock_modes
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // register port
    input wire logic [pmc_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [pmc_pkg::DATA_W-1:0] I_WR_DATA,
    input wire logic I_WR_STB,
    input wire logic I_RD_STB,
    output logic [pmc_pkg::DATA_W-1:0] O_RD_DATA,
    // cpu and wake events
    input wire logic I_SLEEP_EXEC,
    input wire logic I_WAKE_IRQ,
    input wire logic I_WDT_TIMEOUT,
    // configuration straps
    input wire logic I_TWO_SPEED_EN,
    input wire logic I_FAILSAFE_EN,
    input wire logic I_WDT_SELECTED,
    input wire logic I_PRI_IS_INTERNAL,
    // oscillator ready levels
    input wire logic I_PRI_READY,
    input wire logic I_SEC_READY,
    input wire logic I_FAST_INT_READY,
    // clock gating and selection
    output logic O_CPU_CLK_EN,
    output logic O_PERIPH_CLK_EN,
    output logic [1:0] O_SYS_CLK_SEL,
    output logic [2:0] O_INT_FREQ_SEL,
    // oscillator enables
    output logic O_PRI_OSC_EN,
    output logic O_SEC_OSC_EN,
    output logic O_FAST_INT_OSC_EN,
    output logic O_SLOW_INT_OSC_EN,
    // clock status flags
    output logic O_PRIMARY_RUNNING_FLAG,
    output logic O_INTERNAL_STABLE_FLAG,
    output logic O_SECONDARY_RUNNING_FLAG
);

    // =========================================================
    // state
    typedef struct packed
    {
        pmc_pkg::pmc_state_t state;
        pmc_pkg::pmc_src_t cur;
        pmc_pkg::pmc_src_t nxt;
        logic [pmc_pkg::CNT_W-1:0] cnt;
        logic sleep_pend;
        logic idle_pend;
        logic idle_enable;
        logic [2:0] internal_freq_select;
        logic [1:0] clock_select;
        logic secondary_osc_enable;
        logic primary_running_flag;
        logic internal_stable_flag;
        logic secondary_running_flag;
        logic cpu_en;
        logic per_en;
        pmc_pkg::pmc_src_t clk_sel;
        logic pri_osc;
        logic fast_osc;
        logic slow_osc;
        logic sec_osc;
        logic [pmc_pkg::DATA_W-1:0] rdata;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
    } pmc_regs_t;

    pmc_regs_t q_q;
    pmc_regs_t q_d;

    logic pri_rdy;
    logic sec_rdy;
    logic fast_rdy;
    logic wake;
    logic sec_ok;
    logic sleep_go;
    logic sleep_idle;
    logic in_switch;
    pmc_pkg::pmc_src_t tgt;

    assign pri_rdy = q_q.sync_b[0];
    assign sec_rdy = q_q.sync_b[1];
    assign fast_rdy = q_q.sync_b[2];
    assign wake = I_WAKE_IRQ | I_WDT_TIMEOUT;
    assign sec_ok = q_q.secondary_osc_enable & sec_rdy;
    assign sleep_go = I_SLEEP_EXEC | q_q.sleep_pend;
    // a pending sleep keeps the idle-enable value of its own instruction
    assign sleep_idle = I_SLEEP_EXEC ? q_q.idle_enable : q_q.idle_pend;

    // =========================================================
    // helpers
    function automatic pmc_pkg::pmc_src_t want_src(
        input logic [1:0] sel,
        input logic ok,
        input pmc_pkg::pmc_src_t cur
    );
        pmc_pkg::pmc_src_t r;
        r = pmc_pkg::SRC_PRI;
        if (sel[1])
        begin
            r = pmc_pkg::SRC_INT;
        end
        else if (sel[0])
        begin
            r = ok ? pmc_pkg::SRC_SEC : cur;
        end
        return r;
    endfunction

    function automatic logic src_ready(
        input pmc_pkg::pmc_src_t s,
        input logic p_rdy,
        input logic s_rdy
    );
        logic r;
        r = 1'b1;
        case (s)
            pmc_pkg::SRC_PRI: r = p_rdy;
            pmc_pkg::SRC_SEC: r = s_rdy;
            default: r = 1'b1;
        endcase
        return r;
    endfunction

    // flags as {primary running, internal stable, secondary running}
    function automatic logic [2:0] run_flags(
        input pmc_pkg::pmc_src_t s,
        input logic f_rdy,
        input logic pri_int,
        input logic [2:0] freq
    );
        logic [2:0] r;
        r = 3'h0;
        case (s)
            pmc_pkg::SRC_PRI: r = {1'b1, pri_int & f_rdy, 1'b0};
            pmc_pkg::SRC_SEC: r = 3'h1;
            pmc_pkg::SRC_INT: r = {1'b0, f_rdy & (freq != 3'h0), 1'b0};
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    assign tgt = want_src(q_q.clock_select, sec_ok, q_q.cur);

    // =========================================================
    // next state
    always_comb
    begin
        q_d = q_q;
        q_d.sync_a = {I_FAST_INT_READY, I_SEC_READY, I_PRI_READY};
        q_d.sync_b = q_q.sync_a;
        q_d.rdata = 8'h00;
        if (I_WR_STB && I_ADDR == pmc_pkg::ADDR_OSC_CONTROL)
        begin
            q_d.idle_enable = I_WR_DATA[pmc_pkg::OSC_IDLE_BIT];
            // frequency reaches the divider on the next edge
            q_d.internal_freq_select =
                I_WR_DATA[pmc_pkg::OSC_FREQ_LSB +: 3];
            q_d.clock_select = I_WR_DATA[pmc_pkg::OSC_SEL_LSB +: 2];
        end
        if (I_WR_STB && I_ADDR == pmc_pkg::ADDR_TIMER1_CONTROL)
        begin
            q_d.secondary_osc_enable = I_WR_DATA[pmc_pkg::T1_ENABLE_BIT];
        end
        if (I_RD_STB)
        begin
            case (I_ADDR)
                pmc_pkg::ADDR_OSC_CONTROL:
                begin
                    q_d.rdata[pmc_pkg::OSC_IDLE_BIT] = q_q.idle_enable;
                    q_d.rdata[pmc_pkg::OSC_FREQ_LSB +: 3] =
                        q_q.internal_freq_select;
                    q_d.rdata[pmc_pkg::OSC_PRIMARY_RUN_MODE_BIT] =
                        q_q.primary_running_flag;
                    q_d.rdata[pmc_pkg::OSC_INT_STB_BIT] =
                        q_q.internal_stable_flag;
                    q_d.rdata[pmc_pkg::OSC_SEL_LSB +: 2] = q_q.clock_select;
                end
                pmc_pkg::ADDR_TIMER1_CONTROL:
                begin
                    q_d.rdata[pmc_pkg::T1_ENABLE_BIT] =
                        q_q.secondary_osc_enable;
                    q_d.rdata[pmc_pkg::T1_RUNNING_BIT] =
                        q_q.secondary_running_flag;
                end
                pmc_pkg::ADDR_MODE_STATUS:
                begin
                    q_d.rdata = {q_q.cur, 2'h0, q_q.state};
                end
                default: q_d.rdata = 8'h00;
            endcase
        end

        case (q_q.state)
            pmc_pkg::ST_START:
            begin
                // gates stay shut for the switch delay only; ready of the first source is not awaited
                if (I_TWO_SPEED_EN)
                begin
                    q_d.cur = pmc_pkg::SRC_INT;
                    q_d.clk_sel = pmc_pkg::SRC_INT;
                end
                q_d.cnt = pmc_pkg::SWITCH_LOAD;
                q_d.state = pmc_pkg::ST_SW_NEW;
            end
            pmc_pkg::ST_RUN:
            begin
                q_d.sleep_pend = 1'b0;
                if (sleep_go)
                begin
                    q_d.cpu_en = 1'b0;
                    if (sleep_idle)
                    begin
                        // flags keep their run values in idle
                        q_d.state = pmc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        q_d.per_en = 1'b0;
                        q_d.primary_running_flag = 1'b0;
                        q_d.internal_stable_flag = 1'b0;
                        q_d.secondary_running_flag = 1'b0;
                        q_d.state = pmc_pkg::ST_SLEEP;
                    end
                end
                else if (tgt != q_q.cur)
                begin
                    // old clock keeps running while the new one starts
                    q_d.nxt = tgt;
                    q_d.state = pmc_pkg::ST_SW_WAIT;
                end
                else
                begin
                    {q_d.primary_running_flag, q_d.internal_stable_flag,
                        q_d.secondary_running_flag} = run_flags(q_q.cur,
                        fast_rdy, I_PRI_IS_INTERNAL,
                        q_q.internal_freq_select);
                end
            end
            pmc_pkg::ST_SW_WAIT:
            begin
                if (I_SLEEP_EXEC)
                begin
                    q_d.sleep_pend = 1'b1;
                    q_d.idle_pend = q_q.idle_enable;
                end
                if (src_ready(q_q.nxt, pri_rdy, sec_rdy))
                begin
                    q_d.cpu_en = 1'b0;
                    q_d.per_en = 1'b0;
                    q_d.cnt = pmc_pkg::SWITCH_LOAD;
                    q_d.state = pmc_pkg::ST_SW_OLD;
                end
            end
            pmc_pkg::ST_SW_OLD:
            begin
                q_d.cnt = q_q.cnt - 1'b1;
                if (q_q.cnt == '0)
                begin
                    // selector moves only with both gates shut
                    q_d.cur = q_q.nxt;
                    q_d.clk_sel = q_q.nxt;
                    q_d.cnt = pmc_pkg::SWITCH_LOAD;
                    q_d.state = pmc_pkg::ST_SW_NEW;
                end
            end
            pmc_pkg::ST_SW_NEW:
            begin
                q_d.cnt = q_q.cnt - 1'b1;
                if (q_q.cnt == '0)
                begin
                    q_d.cpu_en = 1'b1;
                    q_d.per_en = 1'b1;
                    {q_d.primary_running_flag, q_d.internal_stable_flag,
                        q_d.secondary_running_flag} = run_flags(q_q.cur,
                        fast_rdy, I_PRI_IS_INTERNAL,
                        q_q.internal_freq_select);
                    q_d.state = pmc_pkg::ST_RUN;
                end
            end
            pmc_pkg::ST_SLEEP:
            begin
                if (wake)
                begin
                    // run from the internal block while the target starts
                    if ((I_TWO_SPEED_EN || I_FAILSAFE_EN) &&
                        !src_ready(tgt, pri_rdy, sec_rdy))
                    begin
                        q_d.cur = pmc_pkg::SRC_INT;
                        q_d.clk_sel = pmc_pkg::SRC_INT;
                    end
                    else
                    begin
                        q_d.cur = tgt;
                        q_d.clk_sel = tgt;
                    end
                    q_d.state = pmc_pkg::ST_WAKE_WAIT;
                end
            end
            pmc_pkg::ST_IDLE:
            begin
                if (wake)
                begin
                    q_d.cnt = pmc_pkg::CPU_READY_LOAD;
                    q_d.state = pmc_pkg::ST_WAKE_DELAY;
                end
            end
            pmc_pkg::ST_WAKE_WAIT:
            begin
                // unclocked until the chosen source reports ready
                if (src_ready(q_q.cur, pri_rdy, sec_rdy))
                begin
                    q_d.per_en = 1'b1;
                    q_d.cnt = pmc_pkg::CPU_READY_LOAD;
                    q_d.state = pmc_pkg::ST_WAKE_DELAY;
                end
            end
            pmc_pkg::ST_WAKE_DELAY:
            begin
                q_d.cnt = q_q.cnt - 1'b1;
                if (q_q.cnt == '0)
                begin
                    q_d.cpu_en = 1'b1;
                    q_d.state = pmc_pkg::ST_RUN;
                end
            end
            default: q_d.state = pmc_pkg::ST_START;
        endcase

        // oscillator enables follow the settled next state
        in_switch = q_d.state == pmc_pkg::ST_SW_WAIT ||
            q_d.state == pmc_pkg::ST_SW_OLD ||
            q_d.state == pmc_pkg::ST_SW_NEW;
        q_d.pri_osc = q_d.state != pmc_pkg::ST_SLEEP &&
            (q_d.cur == pmc_pkg::SRC_PRI ||
            (in_switch && q_d.nxt == pmc_pkg::SRC_PRI));
        q_d.fast_osc = q_d.state != pmc_pkg::ST_SLEEP &&
            ((q_d.cur == pmc_pkg::SRC_INT &&
            q_d.internal_freq_select != 3'h0) ||
            (q_d.cur == pmc_pkg::SRC_PRI && I_PRI_IS_INTERNAL) ||
            (in_switch && q_d.nxt == pmc_pkg::SRC_INT));
        q_d.slow_osc = I_WDT_SELECTED || (q_d.state != pmc_pkg::ST_SLEEP &&
            q_d.cur == pmc_pkg::SRC_INT &&
            q_d.internal_freq_select == 3'h0);
        q_d.sec_osc = q_d.secondary_osc_enable;
    end

    // =========================================================
    // registers
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            q_q <= '0;
            q_q.state <= pmc_pkg::ST_START;
            q_q.cur <= pmc_pkg::SRC_PRI;
            q_q.nxt <= pmc_pkg::SRC_PRI;
            q_q.clk_sel <= pmc_pkg::SRC_PRI;
            q_q.idle_enable <= pmc_pkg::OSC_CONTROL_RST[pmc_pkg::OSC_IDLE_BIT];
            q_q.internal_freq_select <=
                pmc_pkg::OSC_CONTROL_RST[pmc_pkg::OSC_FREQ_LSB +: 3];
            q_q.clock_select <=
                pmc_pkg::OSC_CONTROL_RST[pmc_pkg::OSC_SEL_LSB +: 2];
            q_q.secondary_osc_enable <= pmc_pkg::T1_ENABLE_RST;
            q_q.primary_running_flag <= 1'b1;
            q_q.pri_osc <= 1'b1;
        end
        else
        begin
            q_q <= q_d;
        end
    end

    assign O_RD_DATA = q_q.rdata;
    assign O_CPU_CLK_EN = q_q.cpu_en;
    assign O_PERIPH_CLK_EN = q_q.per_en;
    assign O_SYS_CLK_SEL = q_q.clk_sel;
    assign O_INT_FREQ_SEL = q_q.internal_freq_select;
    assign O_PRI_OSC_EN = q_q.pri_osc;
    assign O_SEC_OSC_EN = q_q.sec_osc;
    assign O_FAST_INT_OSC_EN = q_q.fast_osc;
    assign O_SLOW_INT_OSC_EN = q_q.slow_osc;
    assign O_PRIMARY_RUNNING_FLAG = q_q.primary_running_flag;
    assign O_INTERNAL_STABLE_FLAG = q_q.internal_stable_flag;
    assign O_SECONDARY_RUNNING_FLAG = q_q.secondary_running_flag;

    // =========================================================
    // checks
    localparam int DLY = pmc_pkg::CPU_READY_CYC;
    logic [2:0] flags;
    logic run_now;
    assign flags = {O_PRIMARY_RUNNING_FLAG, O_INTERNAL_STABLE_FLAG,
        O_SECONDARY_RUNNING_FLAG};
    assign run_now = q_q.state == pmc_pkg::ST_RUN;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    sequence s_cpu_ready;
        !O_CPU_CLK_EN ##DLY !O_CPU_CLK_EN ##1 O_CPU_CLK_EN;
    endsequence
    sequence s_gates_shut;
        (!O_CPU_CLK_EN && !O_PERIPH_CLK_EN) [*6] ##1
        (O_CPU_CLK_EN && O_PERIPH_CLK_EN);
    endsequence

    a_sleep_stops_all: assert property (
        (run_now && I_SLEEP_EXEC && !q_q.idle_enable && !q_q.sleep_pend)
        |=> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN && flags == 3'h0)
        else $error("sleep left a clock or flag on");
    a_idle_keeps_periph: assert property (
        (run_now && I_SLEEP_EXEC && q_q.idle_enable && !q_q.sleep_pend)
        |=> !O_CPU_CLK_EN && O_PERIPH_CLK_EN && $stable(flags))
        else $error("idle entry wrong");
    a_idle_wake_delay: assert property (
        (q_q.state == pmc_pkg::ST_IDLE && wake) |-> s_cpu_ready)
        else $error("cpu ready delay wrong");
    a_switch_gap_len: assert property (
        (q_q.state == pmc_pkg::ST_SW_WAIT &&
        src_ready(q_q.nxt, pri_rdy, sec_rdy)) |=> s_gates_shut)
        else $error("switch gap length wrong");
    a_sel_moves_quiet: assert property (
        $changed(O_SYS_CLK_SEL) |-> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN
        && !$past(O_PERIPH_CLK_EN))
        else $error("clock select moved while gated on");
    a_sec_postponed: assert property (
        (run_now && q_q.clock_select == 2'h1 && !q_q.secondary_osc_enable
        && q_q.cur != pmc_pkg::SRC_SEC && !sleep_go)
        |=> q_q.nxt != pmc_pkg::SRC_SEC || q_q.state == pmc_pkg::ST_RUN)
        else $error("secondary entered while disabled");
    a_flag_code_run: assert property (
        (run_now && $past(run_now) && q_q.cur == pmc_pkg::SRC_SEC)
        |-> flags == 3'h1)
        else $error("secondary run flags wrong");
    a_pri_osc_off: assert property (
        (run_now && q_q.cur != pmc_pkg::SRC_PRI) |-> !O_PRI_OSC_EN)
        else $error("primary left running");
    a_sec_osc_kept: assert property (
        (I_WR_STB && I_ADDR == pmc_pkg::ADDR_TIMER1_CONTROL &&
        I_WR_DATA[pmc_pkg::T1_ENABLE_BIT]) |=> O_SEC_OSC_EN [*2])
        else $error("secondary oscillator not kept on");
    a_wdt_wakes_run: assert property (
        (q_q.state == pmc_pkg::ST_SLEEP && I_WDT_TIMEOUT)
        |=> q_q.state == pmc_pkg::ST_WAKE_WAIT)
        else $error("watchdog did not wake");

endmodule

`default_nettype wire

// ==== verilog/pmc_pkg.sv ====
// shared constants and types of the power-managed clock mode controller
// assumes a single 100 MHz controller clock and byte-wide registers
package pmc_pkg;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CPU_READY_NS = 200;
    localparam int CPU_READY_CYC =
        (CPU_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // two and a half source cycles, counted in controller half periods
    localparam int SWITCH_HALF_CYCLES = 5;
    localparam int SWITCH_CYC = (SWITCH_HALF_CYCLES + 1) / 2;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] SWITCH_LOAD = CNT_W'(SWITCH_CYC - 1);
    localparam logic [CNT_W-1:0] CPU_READY_LOAD = CNT_W'(CPU_READY_CYC - 1);

    // =========================================================
    // register map
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_OSC_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_TIMER1_CONTROL = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_MODE_STATUS = 2'h2;
    localparam int OSC_IDLE_BIT = 7;
    localparam int OSC_FREQ_LSB = 4;
    localparam int OSC_PRIMARY_RUN_MODE_BIT = 3;
    localparam int OSC_INT_STB_BIT = 2;
    localparam int OSC_SEL_LSB = 0;
    localparam logic [DATA_W-1:0] OSC_CONTROL_RST = 8'h30;
    localparam int T1_ENABLE_BIT = 0;
    localparam int T1_RUNNING_BIT = 1;
    localparam logic T1_ENABLE_RST = 1'h0;

    // =========================================================
    // enumerations
    typedef enum logic [1:0]
    {
        SRC_PRI = 2'b00,
        SRC_SEC = 2'b01,
        SRC_INT = 2'b10
    } pmc_src_t;

    typedef enum logic [3:0]
    {
        ST_START = 4'b0000,
        ST_RUN = 4'b0001,
        ST_SW_WAIT = 4'b0010,
        ST_SW_OLD = 4'b0011,
        ST_SW_NEW = 4'b0100,
        ST_SLEEP = 4'b0101,
        ST_IDLE = 4'b0110,
        ST_WAKE_WAIT = 4'b0111,
        ST_WAKE_DELAY = 4'b1000
    } pmc_state_t;

endpackage
